// File: rtl/lsd_dispatch.sv
// soft interrupt dispatcher for the legacy virtual mode, with apb registers and memory port
//
// How it works
// - feature register reports the virtual mode extension in bit 1.
// - extension off, privilege level 3: call protected handler for the vector.
// - extension off, privilege level below 3: general protection fault.
// - extension on, level below 3, bitmap bit 1: general protection fault.
// - extension on, level 3, bitmap bit 1: protected handler call.
// - extension on, level 3, bitmap bit 0: redirect to legacy vector table.
// - redirect first pushes low 16 flag bits, nested-task and privilege cleared.
// - then pushes code segment and low 16 pointer bits on current stack.
// - then clears interrupt enable and the single-step flag in the same cycle.
// - loads segment and low pointer from table at address 0, upper zero.
// - redirect keeps the legacy virtual mode throughout.
// - interrupt return pops pointer, segment and flags, resuming the program.
// - extension on, level below 3, bitmap bit 0: redirect with virtual flags.
// - that redirect pushes level 3, virtual flag as enable, clears virtual flag.
// - bitmap bit for vector zero sits 32 bytes below the permission map base.
// - hardware interrupts and exceptions always go to protected handlers.
`timescale 1ns/1ps
`include "lsd_consts.svh"

module lsd_dispatch (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // memory port
  output lsd_pkg::lsd_mem_req_t      mem_req,
  input  wire lsd_pkg::lsd_mem_rsp_t mem_rsp,
  // dispatch results
  output logic                       pm_call,
  output logic                       gp_fault,
  output logic [7:0]                 handler_vector
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `LSD_OFF_CR4, `LSD_OFF_FLAGS, `LSD_OFF_CS, `LSD_OFF_IP, `LSD_OFF_SS,
      `LSD_OFF_SP, `LSD_OFF_TSS, `LSD_OFF_IOMAP, `LSD_OFF_CMD,
      `LSD_OFF_STATUS, `LSD_OFF_FEATURE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic lsd_pkg::lsd_method_t pick_method(input logic virt_mode_ext_enable,
                                                       input logic [1:0] io_privilege_level,
                                                       input logic bmap_bit);
    if (!virt_mode_ext_enable)
      pick_method = (io_privilege_level == `LSD_IO_PRIVILEGE_LEVEL_MAX) ? lsd_pkg::M_ONE : lsd_pkg::M_TWO;
    else if (io_privilege_level == `LSD_IO_PRIVILEGE_LEVEL_MAX)
      pick_method = bmap_bit ? lsd_pkg::M_FOUR : lsd_pkg::M_FIVE;
    else
      pick_method = bmap_bit ? lsd_pkg::M_THR : lsd_pkg::M_SIX;
  endfunction : pick_method

  function automatic logic [31:0] seg_lin(input logic [15:0] seg, input logic [15:0] off);
    seg_lin = {12'h000, seg, 4'h0} + {16'h0000, off};
  endfunction : seg_lin

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lsd_pkg::lsd_state_t   state_r,   state_nxt;
  lsd_pkg::lsd_method_t  method_r,  method_nxt;
  lsd_pkg::lsd_outcome_t outcome_r, outcome_nxt;
  lsd_pkg::lsd_mem_req_t mem_r,     mem_nxt;
  logic        vme_r,      vme_nxt;
  logic [31:0] flags_r,    flags_nxt;
  logic [15:0] cs_r,       cs_nxt;
  logic [31:0] ip_r,       ip_nxt;
  logic [15:0] ss_r,       ss_nxt;
  logic [15:0] sp_r,       sp_nxt;
  logic [31:0] tss_r,      tss_nxt;
  logic [15:0] iomap_r,    iomap_nxt;
  logic [7:0]  vec_r,      vec_nxt;
  logic [15:0] tmp_r,      tmp_nxt;
  logic        pready_r,   pready_nxt;
  logic [31:0] prdata_r,   prdata_nxt;
  logic        pslverr_r,  pslverr_nxt;
  logic        pm_call_r,  pm_call_nxt;
  logic        gp_r,       gp_nxt;

  logic        access;
  logic        wr_fire;
  logic        busy;
  logic        bad;
  logic [15:0] fl_img;

  assign access  = psel & penable;
  assign busy    = (state_r != lsd_pkg::ST_IDLE);
  // apb writes to the state registers are only taken while the sequencer rests
  assign bad     = ~is_mapped(paddr) | (pwrite & busy & (paddr != `LSD_OFF_STATUS));
  assign wr_fire = access & pready_r & pwrite & ~pslverr_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt   = state_r;
    method_nxt  = method_r;
    outcome_nxt = outcome_r;
    vme_nxt     = vme_r;
    flags_nxt   = flags_r;
    cs_nxt      = cs_r;
    ip_nxt      = ip_r;
    ss_nxt      = ss_r;
    sp_nxt      = sp_r;
    tss_nxt     = tss_r;
    iomap_nxt   = iomap_r;
    vec_nxt     = vec_r;
    tmp_nxt     = tmp_r;
    pm_call_nxt = 1'b0;
    gp_nxt      = 1'b0;
    fl_img      = flags_r[15:0];
    mem_nxt     = '0;

    // apb: one wait cycle so that every answer comes from a flip-flop
    pready_nxt  = access & ~pready_r;
    pslverr_nxt = access & ~pready_r & bad;
    prdata_nxt  = 32'h00000000;
    if (access && !pready_r && !pwrite && !bad)
    begin
      case (paddr)
        `LSD_OFF_CR4:     prdata_nxt = {31'h00000000, vme_r};
        `LSD_OFF_FLAGS:   prdata_nxt = flags_r;
        `LSD_OFF_CS:      prdata_nxt = {16'h0000, cs_r};
        `LSD_OFF_IP:      prdata_nxt = ip_r;
        `LSD_OFF_SS:      prdata_nxt = {16'h0000, ss_r};
        `LSD_OFF_SP:      prdata_nxt = {16'h0000, sp_r};
        `LSD_OFF_TSS:     prdata_nxt = tss_r;
        `LSD_OFF_IOMAP:   prdata_nxt = {16'h0000, iomap_r};
        `LSD_OFF_CMD:     prdata_nxt = {24'h000000, vec_r};
        `LSD_OFF_STATUS:  prdata_nxt = {25'h0000000, outcome_r, method_r, busy};
        `LSD_OFF_FEATURE: prdata_nxt = `LSD_FEATURE_VAL;
        default:          prdata_nxt = 32'h00000000;
      endcase
    end

    if (wr_fire)
    begin
      case (paddr)
        `LSD_OFF_CR4:   vme_nxt   = pwdata[`LSD_CR4_VME];
        `LSD_OFF_FLAGS: flags_nxt = pwdata;
        `LSD_OFF_CS:    cs_nxt    = pwdata[15:0];
        `LSD_OFF_IP:    ip_nxt    = pwdata;
        `LSD_OFF_SS:    ss_nxt    = pwdata[15:0];
        `LSD_OFF_SP:    sp_nxt    = pwdata[15:0];
        `LSD_OFF_TSS:   tss_nxt   = pwdata;
        `LSD_OFF_IOMAP: iomap_nxt = pwdata[15:0];
        `LSD_OFF_CMD:
        begin
          vec_nxt     = pwdata[7:0];
          method_nxt  = lsd_pkg::M_NONE;
          outcome_nxt = lsd_pkg::OC_NONE;
          if (pwdata[`LSD_CMD_HW] || !flags_r[`LSD_FL_VM])
          begin
            // the bitmap is never consulted here
            outcome_nxt = lsd_pkg::OC_PM_CALL;
            pm_call_nxt = 1'b1;
          end
          else if (pwdata[`LSD_CMD_INTERRUPT_RETURN])
            state_nxt = lsd_pkg::ST_POP_IP;
          else if (!vme_r)
          begin
            method_nxt = pick_method(1'b0, flags_r[`LSD_FL_IO_PRIVILEGE_LEVEL_HI:`LSD_FL_IO_PRIVILEGE_LEVEL_LO],
                                     1'b0);
            if (method_nxt == lsd_pkg::M_ONE)
            begin
              outcome_nxt = lsd_pkg::OC_PM_CALL;
              pm_call_nxt = 1'b1;
            end
            else
            begin
              outcome_nxt = lsd_pkg::OC_GP_FAULT;
              gp_nxt      = 1'b1;
            end
          end
          else
            state_nxt = lsd_pkg::ST_BMAP;
        end
        default: ;
      endcase
    end

    case (state_r)
      lsd_pkg::ST_IDLE: ;
      lsd_pkg::ST_BMAP:
        if (mem_rsp.ack)
        begin
          method_nxt = pick_method(vme_r, flags_r[`LSD_FL_IO_PRIVILEGE_LEVEL_HI:`LSD_FL_IO_PRIVILEGE_LEVEL_LO],
                                   mem_rsp.rdata[vec_r[2:0]]);
          case (method_nxt)
            lsd_pkg::M_THR:
            begin
              outcome_nxt = lsd_pkg::OC_GP_FAULT;
              gp_nxt      = 1'b1;
              state_nxt   = lsd_pkg::ST_IDLE;
            end
            lsd_pkg::M_FOUR:
            begin
              outcome_nxt = lsd_pkg::OC_PM_CALL;
              pm_call_nxt = 1'b1;
              state_nxt   = lsd_pkg::ST_IDLE;
            end
            default: state_nxt = lsd_pkg::ST_PUSH_FL;
          endcase
        end
      lsd_pkg::ST_PUSH_FL:
        if (mem_rsp.ack)
        begin
          sp_nxt    = sp_r - 16'h0002;
          state_nxt = lsd_pkg::ST_PUSH_CS;
        end
      lsd_pkg::ST_PUSH_CS:
        if (mem_rsp.ack)
        begin
          sp_nxt    = sp_r - 16'h0002;
          state_nxt = lsd_pkg::ST_PUSH_IP;
        end
      lsd_pkg::ST_PUSH_IP:
        if (mem_rsp.ack)
        begin
          sp_nxt = sp_r - 16'h0002;
          if (method_r == lsd_pkg::M_SIX)
            flags_nxt[`LSD_FL_VIF] = 1'b0;
          else
            flags_nxt[`LSD_FL_IF] = 1'b0;
          flags_nxt[`LSD_FL_TF] = 1'b0;
          state_nxt = lsd_pkg::ST_VEC_IP;
        end
      lsd_pkg::ST_VEC_IP:
        if (mem_rsp.ack)
        begin
          tmp_nxt   = mem_rsp.rdata;
          state_nxt = lsd_pkg::ST_VEC_CS;
        end
      lsd_pkg::ST_VEC_CS:
        if (mem_rsp.ack)
        begin
          // the vm flag is left alone: the handler runs in the legacy mode
          cs_nxt      = mem_rsp.rdata;
          ip_nxt      = {16'h0000, tmp_r};
          outcome_nxt = lsd_pkg::OC_REDIRECT;
          state_nxt   = lsd_pkg::ST_IDLE;
        end
      lsd_pkg::ST_POP_IP:
        if (mem_rsp.ack)
        begin
          ip_nxt    = {16'h0000, mem_rsp.rdata};
          sp_nxt    = sp_r + 16'h0002;
          state_nxt = lsd_pkg::ST_POP_CS;
        end
      lsd_pkg::ST_POP_CS:
        if (mem_rsp.ack)
        begin
          cs_nxt    = mem_rsp.rdata;
          sp_nxt    = sp_r + 16'h0002;
          state_nxt = lsd_pkg::ST_POP_FL;
        end
      lsd_pkg::ST_POP_FL:
        if (mem_rsp.ack)
        begin
          // the privilege level and nested-task bit are not taken from the image
          flags_nxt[`LSD_FL_TF] = mem_rsp.rdata[`LSD_FL_TF];
          flags_nxt[7:0]        = mem_rsp.rdata[7:0];
          flags_nxt[11:10]      = mem_rsp.rdata[11:10];
          if (vme_r && flags_r[`LSD_FL_IO_PRIVILEGE_LEVEL_HI:`LSD_FL_IO_PRIVILEGE_LEVEL_LO] != `LSD_IO_PRIVILEGE_LEVEL_MAX)
            flags_nxt[`LSD_FL_VIF] = mem_rsp.rdata[`LSD_FL_IF];
          else
            flags_nxt[`LSD_FL_IF] = mem_rsp.rdata[`LSD_FL_IF];
          sp_nxt      = sp_r + 16'h0002;
          outcome_nxt = lsd_pkg::OC_RETURN;
          state_nxt   = lsd_pkg::ST_IDLE;
        end
      default: state_nxt = lsd_pkg::ST_IDLE;
    endcase

    // memory request for the next state, with one idle cycle after each acknowledge
    if (method_nxt == lsd_pkg::M_SIX)
    begin
      fl_img[`LSD_FL_IO_PRIVILEGE_LEVEL_HI:`LSD_FL_IO_PRIVILEGE_LEVEL_LO] = `LSD_IO_PRIVILEGE_LEVEL_MAX;
      fl_img[`LSD_FL_IF] = flags_r[`LSD_FL_VIF];
    end
    else
    begin
      fl_img[`LSD_FL_IO_PRIVILEGE_LEVEL_HI:`LSD_FL_IO_PRIVILEGE_LEVEL_LO] = 2'h0;
      fl_img[`LSD_FL_NT] = 1'b0;
    end
    if (!mem_rsp.ack || !busy)
    begin
      case (state_nxt)
        lsd_pkg::ST_BMAP:
        begin
          mem_nxt.valid = 1'b1;
          mem_nxt.addr  = tss_r + {16'h0000, iomap_r} - `LSD_BMAP_BYTES
                          + {27'h0000000, vec_nxt[7:3]};
        end
        lsd_pkg::ST_PUSH_FL:
        begin
          mem_nxt.valid = 1'b1;
          mem_nxt.write = 1'b1;
          mem_nxt.addr  = seg_lin(ss_r, sp_nxt - 16'h0002);
          mem_nxt.wdata = fl_img;
        end
        lsd_pkg::ST_PUSH_CS, lsd_pkg::ST_PUSH_IP:
        begin
          mem_nxt.valid = 1'b1;
          mem_nxt.write = 1'b1;
          mem_nxt.addr  = seg_lin(ss_r, sp_nxt - 16'h0002);
          mem_nxt.wdata = (state_nxt == lsd_pkg::ST_PUSH_CS) ? cs_r : ip_r[15:0];
        end
        lsd_pkg::ST_VEC_IP, lsd_pkg::ST_VEC_CS:
        begin
          mem_nxt.valid = 1'b1;
          mem_nxt.addr  = {22'h000000, vec_r, (state_nxt == lsd_pkg::ST_VEC_CS), 1'b0};
        end
        lsd_pkg::ST_POP_IP, lsd_pkg::ST_POP_CS, lsd_pkg::ST_POP_FL:
        begin
          mem_nxt.valid = 1'b1;
          mem_nxt.addr  = seg_lin(ss_nxt, sp_nxt);
        end
        default: mem_nxt = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r   <= lsd_pkg::ST_IDLE;
      method_r  <= lsd_pkg::M_NONE;
      outcome_r <= lsd_pkg::OC_NONE;
      mem_r     <= '0;
      vme_r     <= 1'b0;
      flags_r   <= `LSD_RST_FLAGS;
      cs_r      <= 16'h0000;
      ip_r      <= 32'h00000000;
      ss_r      <= 16'h0000;
      sp_r      <= 16'h0000;
      tss_r     <= 32'h00000000;
      iomap_r   <= 16'h0000;
      vec_r     <= 8'h00;
      tmp_r     <= 16'h0000;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
      pm_call_r <= 1'b0;
      gp_r      <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      method_r  <= method_nxt;
      outcome_r <= outcome_nxt;
      mem_r     <= mem_nxt;
      vme_r     <= vme_nxt;
      flags_r   <= flags_nxt;
      cs_r      <= cs_nxt;
      ip_r      <= ip_nxt;
      ss_r      <= ss_nxt;
      sp_r      <= sp_nxt;
      tss_r     <= tss_nxt;
      iomap_r   <= iomap_nxt;
      vec_r     <= vec_nxt;
      tmp_r     <= tmp_nxt;
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      pm_call_r <= pm_call_nxt;
      gp_r      <= gp_nxt;
    end
  end

  assign pready         = pready_r;
  assign prdata         = prdata_r;
  assign pslverr        = pslverr_r;
  assign mem_req        = mem_r;
  assign pm_call        = pm_call_r;
  assign gp_fault       = gp_r;
  assign handler_vector = vec_r;

endmodule : lsd_dispatch

// File: rtl/lsd_consts.svh
// register offsets, flag bit positions and reset values for the soft interrupt dispatcher
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LSD_OFF_CR4      12'h000
`define LSD_OFF_FLAGS    12'h004
`define LSD_OFF_CS       12'h008
`define LSD_OFF_IP       12'h00C
`define LSD_OFF_SS       12'h010
`define LSD_OFF_SP       12'h014
`define LSD_OFF_TSS      12'h018
`define LSD_OFF_IOMAP    12'h01C
`define LSD_OFF_CMD      12'h020
`define LSD_OFF_STATUS   12'h024
`define LSD_OFF_FEATURE  12'h028

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LSD_CR4_VME      0
`define LSD_FL_TF        8
`define LSD_FL_IF        9
`define LSD_FL_IO_PRIVILEGE_LEVEL_LO   12
`define LSD_FL_IO_PRIVILEGE_LEVEL_HI   13
`define LSD_FL_NT        14
`define LSD_FL_VM        17
`define LSD_FL_VIF       19
`define LSD_FL_VIP       20
`define LSD_CMD_INTERRUPT_RETURN     8
`define LSD_CMD_HW       9

// ----------------------------------------------------------------
// reset values and fixed numbers
// ----------------------------------------------------------------
`define LSD_RST_FLAGS    32'h00020002
`define LSD_FEATURE_VAL  32'h00000002
`define LSD_BMAP_BYTES   32'h00000020
`define LSD_IO_PRIVILEGE_LEVEL_MAX     2'h3

`endif

// File: rtl/lsd_pkg.sv
// types shared by the soft interrupt dispatcher
package lsd_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_BMAP    = 4'h1,
    ST_PUSH_FL = 4'h2,
    ST_PUSH_CS = 4'h3,
    ST_PUSH_IP = 4'h4,
    ST_VEC_IP  = 4'h5,
    ST_VEC_CS  = 4'h6,
    ST_POP_IP  = 4'h7,
    ST_POP_CS  = 4'h8,
    ST_POP_FL  = 4'h9
  } lsd_state_t;

  typedef enum logic [2:0] {
    M_NONE = 3'h0,
    M_ONE  = 3'h1,
    M_TWO  = 3'h2,
    M_THR  = 3'h3,
    M_FOUR = 3'h4,
    M_FIVE = 3'h5,
    M_SIX  = 3'h6
  } lsd_method_t;

  typedef enum logic [2:0] {
    OC_NONE     = 3'h0,
    OC_PM_CALL  = 3'h1,
    OC_GP_FAULT = 3'h2,
    OC_REDIRECT = 3'h3,
    OC_RETURN   = 3'h4
  } lsd_outcome_t;

  // ----------------------------------------------------------------
  // memory port carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [15:0] wdata;
  } lsd_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } lsd_mem_rsp_t;

endpackage : lsd_pkg

// File: verif/lsd_dispatch_asserts.sv
// port checker for the soft interrupt dispatcher
`timescale 1ns/1ps
module lsd_dispatch_chk (
  // clock, reset and apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic [31:0]           prdata,
  input wire logic                  pslverr,
  // memory port and results
  input wire lsd_pkg::lsd_mem_req_t mem_req,
  input wire lsd_pkg::lsd_mem_rsp_t mem_rsp,
  input wire logic                  pm_call,
  input wire logic                  gp_fault,
  input wire logic [7:0]            handler_vector
);
  // shadow of the selection inputs, kept from accepted writes
  logic        vme_r, vme_nxt, bm_r, bm_nxt;
  logic [2:0]  fl_r, fl_nxt;
  logic [31:0] tss_r, tss_nxt, map_r, map_nxt;
  wire take = psel && penable && pready && pwrite && !pslverr;
  wire cmd  = take && paddr == 12'h020 && pwdata[9:8] == 2'h0 && fl_r[2];
  wire bmk  = bm_r && mem_req.valid && mem_rsp.ack;
  wire hit  = mem_rsp.rdata[handler_vector[2:0]];
  always_comb
  begin
    vme_nxt = (take && paddr == 12'h000) ? pwdata[0] : vme_r;
    fl_nxt  = (take && paddr == 12'h004) ? {pwdata[17], pwdata[13:12]} : fl_r;
    tss_nxt = (take && paddr == 12'h018) ? pwdata : tss_r;
    map_nxt = (take && paddr == 12'h01C) ? {16'h0, pwdata[15:0]} : map_r;
    bm_nxt  = (cmd && vme_r) ? 1'b1 : (bmk ? 1'b0 : bm_r);
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {vme_r, bm_r, fl_r, tss_r, map_r} <= {5'h04, 64'h0};
    else
      {vme_r, bm_r, fl_r, tss_r, map_r} <= {vme_nxt, bm_nxt, fl_nxt, tss_nxt, map_nxt};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_feature_bit: assert property (psel && penable && pready && !pwrite &&
    paddr == 12'h028 |-> prdata == 32'h00000002) else $error("feature word wrong");
  a_off_call: assert property (cmd && !vme_r && fl_r[1:0] == 2'h3
    |=> pm_call && !gp_fault) else $error("no handler call");
  a_off_fault: assert property (cmd && !vme_r && fl_r[1:0] != 2'h3
    |=> gp_fault && !pm_call) else $error("no protection fault");
  a_hw_call: assert property (take && paddr == 12'h020 && pwdata[9:8] == 2'h2
    && fl_r[2] |=> pm_call) else $error("hardware event not called");
  a_bmap_addr: assert property (cmd && vme_r |=> mem_req.valid && !mem_req.write
    && mem_req.addr == tss_r + map_r - 32'h20 + {27'h0, handler_vector[7:3]})
    else $error("bitmap address wrong");
  a_set_fault: assert property (bmk && hit && fl_r[1:0] != 2'h3 |=> gp_fault)
    else $error("set bit, low level: no fault");
  a_set_call: assert property (bmk && hit && fl_r[1:0] == 2'h3 |=> pm_call)
    else $error("set bit, level 3: no call");
  a_push_plain: assert property (bmk && !hit && fl_r[1:0] == 2'h3 |->
    ##[1:4] (mem_req.valid && mem_req.write && mem_req.wdata[14:12] == 3'h0))
    else $error("redirect image wrong");
  a_push_virt: assert property (bmk && !hit && fl_r[1:0] != 2'h3 |->
    ##[1:4] (mem_req.valid && mem_req.write && mem_req.wdata[13:12] == 2'h3))
    else $error("virtual redirect image wrong");
  a_one_result: assert property (!(pm_call && gp_fault))
    else $error("call and fault together");
  c_ext_off: cover property (cmd && !vme_r);
  c_redirect: cover property (bmk && !hit);
  c_set_bit: cover property (bmk && hit);
endmodule : lsd_dispatch_chk

bind lsd_dispatch lsd_dispatch_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .pm_call(pm_call), .gp_fault(gp_fault), .handler_vector(handler_vector));

// File: verif/test_lsd_dispatch.sv
// self-checking bench for the soft interrupt dispatcher
`timescale 1ns/1ps
module test_lsd_dispatch;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic                  chk_on = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h0;
  logic                  pready, pslverr, pm_call, gp_fault;
  logic [31:0]           prdata;
  logic [7:0]            handler_vector;
  lsd_pkg::lsd_mem_req_t mem_req;
  lsd_pkg::lsd_mem_rsp_t mem_rsp = '0;
  logic [32:0]           q[$];
  logic [47:0]           pq[$];
  logic [9:0]            eq[$];
  logic [7:0]            mem[logic [31:0]];
  logic [31:0]           lf = 32'h229B;
  logic [31:0]           ma;
  logic [1:0]            dly = 2'h0;
  logic [3:0]            cfg [6] = '{4'h6, 4'h3, 4'hD, 4'hF, 4'hE, 4'h8};
  int                    n_fail = 0;
  int                    compares = 0;
  int                    cyc = 0;

  lsd_dispatch DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .mem_req(mem_req), .mem_rsp(mem_rsp), .pm_call(pm_call),
    .gp_fault(gp_fault), .handler_vector(handler_vector));

  initial forever #10 pclk = ~pclk;

  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic c, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk_on <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next setup never drives psel twice in one step
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    q.push_back({e, 32'h0});
    xfer(1'b1, a, d, 1'b1, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    q.push_back({e, d});
    xfer(1'b0, a, 32'h0, 1'b1, r);
  endtask : rd

  task automatic idle;
    logic [31:0] r;
    r = 32'h1;
    while (r[0] !== 1'b0) xfer(1'b0, 12'h024, 32'h0, 1'b0, r);
  endtask : idle

  // c holds {extension, level, bitmap bit}
  task automatic run(input logic [3:0] c, input logic [2:0] m, input logic hw);
    logic [31:0] f, va, ba;
    logic [2:0]  oc;
    logic [7:0]  v;
    logic [15:0] img;
    lf = nx(lf);
    v = lf[7:0];
    lf = nx(lf);
    f = 32'h000A4102 | {18'h0, c[2:1], 12'h0} | {22'h0, m == 3'h5, 9'h0};
    oc = (hw || m == 3'h1 || m == 3'h4) ? 3'h1 : (m < 3'h4 ? 3'h2 : 3'h3);
    va = {22'h0, v, 2'h0};
    ba = 32'h4000 + 32'h68 - 32'h20 + {27'h0, v[7:3]};
    for (int k = 0; k < 4; k++) mem[va + k] = lf[8*k +: 8];
    mem[ba] = c[0] ? 8'h01 << v[2:0] : ~(8'h01 << v[2:0]);
    img = m == 3'h5 ? f[15:0] & 16'h8FFF : {f[15:14], 2'h3, f[11:10], f[19], f[8:0]};
    wr(12'h000, {31'h0, c[3]}, 1'b0);
    wr(12'h004, f, 1'b0);
    wr(12'h00C, 32'h00050ABC, 1'b0);
    wr(12'h014, 32'h00000100, 1'b0);
    if (oc != 3'h3)
      eq.push_back({oc == 3'h1, oc == 3'h2, v});
    else
    begin
      pq.push_back({32'h000020FE, img});
      pq.push_back({32'h000020FC, 16'h1234});
      pq.push_back({32'h000020FA, 16'h0ABC});
    end
    wr(12'h020, {22'h0, hw, 1'b0, v}, 1'b0);
    if (oc == 3'h3) wr(12'h000, 32'h0, 1'b1);
    idle();
    if (!hw) rd(12'h024, {25'h0, oc, m, 1'b0}, 1'b0);
    if (oc == 3'h3)
    begin
      rd(12'h00C, {16'h0, lf[15:0]}, 1'b0);
      rd(12'h008, {16'h0, lf[31:16]}, 1'b0);
      rd(12'h004, f & ~(m == 3'h5 ? 32'h300 : 32'h80100), 1'b0);
      rd(12'h014, 32'h000000FA, 1'b0);
      wr(12'h020, 32'h00000100, 1'b0);
      idle();
      rd(12'h00C, 32'h00000ABC, 1'b0);
      rd(12'h008, 32'h00001234, 1'b0);
      rd(12'h004, f, 1'b0);
      rd(12'h014, 32'h00000100, 1'b0);
    end
    chk(64'(eq.size() + pq.size()), 64'h0);
  endtask : run

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && chk_on)
      chk(64'({pslverr, pwrite ? 32'h0 : prdata}), 64'(q.pop_front()));

  always @(posedge pclk)
    if (pm_call === 1'b1 || gp_fault === 1'b1)
      chk(64'({pm_call, gp_fault, handler_vector}), 64'(eq.pop_front()));

  // memory with a random answer delay; idle read data toggles so stale values never pass
  always @(posedge pclk)
  begin
    if (mem_req.valid === 1'b1 && !mem_rsp.ack && dly == 2'h0)
    begin
      ma = mem_req.addr;
      mem_rsp.ack <= 1'b1;
      dly <= lf[1:0];
      if (mem_req.write)
      begin
        chk(64'({ma, mem_req.wdata}), 64'(pq.pop_front()));
        mem[ma] = mem_req.wdata[7:0];
        mem[ma + 1] = mem_req.wdata[15:8];
        mem_rsp.rdata <= ~mem_rsp.rdata;
      end
      else
        mem_rsp.rdata <= {mem[ma + 1], mem[ma]};
    end
    else
    begin
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (mem_req.valid === 1'b1 && !mem_rsp.ack)
        dly <= dly - 2'h1;
    end
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h028, 32'h00000002, 1'b0);
    rd(12'h004, 32'h00020002, 1'b0);
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h03C, 32'h0, 1'b1);
    wr(12'h008, 32'h00001234, 1'b0);
    wr(12'h010, 32'h00000200, 1'b0);
    wr(12'h018, 32'h00004000, 1'b0);
    wr(12'h01C, 32'h00000068, 1'b0);
    for (int i = 0; i < 6; i++) run(cfg[i], 3'(i + 1), 1'b0);
    run(4'hE, 3'h5, 1'b1);
    // outside the legacy virtual mode every command is a protected call
    wr(12'h004, 32'h00000002, 1'b0);
    eq.push_back(10'h25A);
    wr(12'h020, 32'h0000005A, 1'b0);
    idle();
    rd(12'h024, 32'h00000010, 1'b0);
    chk(64'(eq.size()), 64'h0);
    wrap_up();
  end
endmodule : test_lsd_dispatch
